// file: pflo_defines.svh
// Purpose: constants for the pwm fault / limit override slice
// Assumes: 16-bit registers on a 32-bit classic wishbone bus, byte addresses
// Notes: every offset, control field position, reset value and mask lives here
// Behaviour
// - normal mode limit drives high from upper bit
// - normal mode limit drives low from lower bit
// - independent mode ignores limit state bits
// - exchange bit swaps high and low pins
// - sync bit set: overrides at period boundary
// - sync bit clear: overrides next clock edge
// - override states pass through output polarity
// - 13-bit compare field fires adc trigger
// - trigger register low three bits read zero
// - independent mode fault forces low, limit high
// - fault mode encodings disabled reserved cycle latched
// - fault polarity one means active low
`ifndef PFLO_DEFINES_SVH
`define PFLO_DEFINES_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define PFLO_OFS_OUTCTL 4'h0
`define PFLO_OFS_TRIG 4'h4
`define PFLO_OFS_FLCTL 4'h8
`define PFLO_OFS_STATUS 4'hC
// ----------------------------------------
// output control fields
// ----------------------------------------
`define PFLO_OC_HPOL 15
`define PFLO_OC_LPOL 14
`define PFLO_OC_OVRH 9
`define PFLO_OC_OVRL 8
`define PFLO_OC_OVDH 7
`define PFLO_OC_OVDL 6
`define PFLO_OC_FDH 5
`define PFLO_OC_FDL 4
`define PFLO_OC_CDH 3
`define PFLO_OC_CDL 2
`define PFLO_OC_SWAP 1
`define PFLO_OC_OVERRIDE_SYNC 0
// ----------------------------------------
// fault / limit control fields
// ----------------------------------------
`define PFLO_FC_IFLT 15
`define PFLO_FC_LIMIT_SOURCE_SELECT_HI 14
`define PFLO_FC_LIMIT_SOURCE_SELECT_LO 10
`define PFLO_FC_LIMIT_POLARITY 9
`define PFLO_FC_CLEN 8
`define PFLO_FC_FSRC_HI 7
`define PFLO_FC_FSRC_LO 3
`define PFLO_FC_FPOL 2
`define PFLO_FC_FMOD_HI 1
`define PFLO_FC_FMOD_LO 0
// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define PFLO_RST_OUTCTL 16'h0000
`define PFLO_RST_FLCTL 16'h00F8
`define PFLO_RST_TRIG 16'h0000
`define PFLO_TRIG_MASK 16'hFFF8
`define PFLO_TRIG_LSB 3
`define PFLO_FMOD_OFF 2'h3
`define PFLO_FMOD_RSVD 2'h2
`define PFLO_FMOD_CYCLE 2'h1
`define PFLO_FMOD_LATCH 2'h0
`endif

// file: pflo_pkg.sv
// Purpose: types shared by the override slice
// Assumes: nothing beyond the defines header
// Notes: fault mode enum mirrors the two-bit field
package pflo_pkg;
  typedef logic [15:0] pflo_word_t;
  typedef enum logic [1:0] {
    PFLO_FM_LATCH,
    PFLO_FM_CYCLE,
    PFLO_FM_RSVD,
    PFLO_FM_OFF
  } pflo_fmode_e;
endpackage

// file: pflo_srcsel.sv
// Purpose: pick one fault or comparator input and qualify its polarity
// Assumes: index 0..31 maps straight onto the input vector
// Notes: unconnected indices read inactive; combinational only
`timescale 1ns/1ps
`include "pflo_defines.svh"
module pflo_srcsel
  import pflo_pkg::*;
#(
  parameter int NSRC = 32
) (
  input wire logic [NSRC-1:0] src_i,
  input wire logic [4:0] sel_i,
  input wire logic act_low_i,
  output logic active_o
);
  initial begin
    if (NSRC < 1 || NSRC > 32) $error("pflo_srcsel: NSRC out of range");
  end
  // ----------------------------------------
  // selection and polarity
  // ----------------------------------------
  // out of range index gives an idle raw level, so it never asserts
  logic raw;
  always_comb begin
    raw = act_low_i;
    if (32'(sel_i) < NSRC) begin
      raw = src_i[sel_i];
    end
    active_o = raw ^ act_low_i;
  end
endmodule

// file: pflo_tb.sv
// Purpose: self-checking bench for the pwm fault / limit override slice
// Assumes: wishbone answers one cycle after the taking edge, pins settle one edge later
// Notes: no random stimulus; every wait is bounded and a timeout counts as a mismatch
`timescale 1ns/1ps
`include "pflo_defines.svh"
module tb;
  import pflo_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk_i = 1'b0; // 200 MHz bench clock
  logic rst_i = 1'b1; // sync reset, held for three cycles
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, wb_err_o;
  logic timebase_enable_i = 1'b0, period_end_i = 1'b0;
  logic [12:0] count_i = 13'h0000;
  logic pwm_h_i = 1'b0, pwm_l_i = 1'b0;
  logic [31:0] src_i = 32'h0000_0000; // all sources quiet so the default fault stays off
  logic high_output_o, low_output_o, adc_trig_o;
  int err_count = 0;
  int tests_run = 0;
  logic [31:0] rdat;
  logic berr;
  int n;
  // ----------------------------------------
  // clock and design
  // ----------------------------------------
  always #2.5 clk_i = ~clk_i;
  pflo_top u_pflo_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .timebase_enable_i(timebase_enable_i), .period_end_i(period_end_i), .count_i(count_i),
    .pwm_h_i(pwm_h_i), .pwm_l_i(pwm_l_i), .src_i(src_i), .high_output_o(high_output_o),
    .low_output_o(low_output_o), .adc_trig_o(adc_trig_o));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // single place where the run ends
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // compare seen against expected, case equality so x never matches
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one classic cycle; request held until ack or err is sampled high
  task automatic bus(input logic we, input logic [3:0] adr, input logic [15:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_count++;
      finish_test();
    end
    rdat = wb_dat_o;
    berr = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 16'h0000);
    chk(rdat, exp);
  endtask
  // pins are registered: give the change two edges before looking
  task automatic pins(input logic [1:0] exp);
    repeat (2) @(posedge clk_i);
    chk({30'h0000_0000, high_output_o, low_output_o}, {30'h0000_0000, exp});
  endtask
  // sweep the counter past a compare value and count trigger pulses
  task automatic sweep(input int exp);
    int hits;
    hits = 0;
    for (int i = 0; i < 28; i++) begin
      @(posedge clk_i);
      count_i <= 13'(90 + i);
      if (adc_trig_o === 1'b1) hits++;
    end
    chk(32'(hits), 32'(exp));
  endtask
  // fault source 7 at a given mode and polarity, asserted then released
  task automatic fault_case(input logic [1:0] m, input logic p, input logic [1:0] on,
                            input logic [1:0] off);
    bus(1'b1, `PFLO_OFS_FLCTL, {8'h00, 5'd7, p, m});
    src_i[7] <= ~p; // active level depends on polarity
    pins(on);
    src_i[7] <= p;
    pins(off);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped offset
    rd_chk(`PFLO_OFS_OUTCTL, 32'h0000_0000);
    rd_chk(`PFLO_OFS_FLCTL, 32'h0000_00F8);
    rd_chk(`PFLO_OFS_TRIG, 32'h0000_0000);
    bus(1'b0, 4'h2, 16'h0000);
    chk({31'h0000_0000, berr}, 32'h0000_0001);
    // trigger register: low three bits never stick
    bus(1'b1, `PFLO_OFS_TRIG, 16'hFFFF);
    rd_chk(`PFLO_OFS_TRIG, 32'h0000_FFF8);
    bus(1'b1, `PFLO_OFS_TRIG, 16'h0320); // compare value 100 in bits 15:3
    rd_chk(`PFLO_OFS_TRIG, 32'h0000_0320);
    timebase_enable_i <= 1'b1;
    sweep(1);
    timebase_enable_i <= 1'b0;
    // every control write from here on happens with the time base stopped
    sweep(0);
    // generated signals, exchange and polarity
    pwm_h_i <= 1'b1;
    pins(2'b10);
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h0002);
    pins(2'b01);
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h8000);
    pins(2'b00);
    // overrides without sync land at once: high forced active, low inactive
    pwm_h_i <= 1'b0;
    pwm_l_i <= 1'b1;
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h0380);
    pins(2'b10);
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h8380);
    pins(2'b00);
    // overrides with sync wait for the period boundary; drop the old ones unsynchronised first
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h0000);
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h0001);
    pins(2'b01);
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h0381);
    repeat (6) @(posedge clk_i);
    pins(2'b01);
    period_end_i <= 1'b1;
    @(posedge clk_i);
    period_end_i <= 1'b0;
    pins(2'b10);
    // normal mode current limit on source 5, fault disabled
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h0008);
    bus(1'b1, `PFLO_OFS_FLCTL, 16'h15FB);
    src_i[5] <= 1'b1;
    pins(2'b10);
    src_i[5] <= 1'b0;
    pins(2'b01);
    bus(1'b1, `PFLO_OFS_FLCTL, 16'h14FB); // enable off, source still quiet
    src_i[5] <= 1'b1;
    pins(2'b01);
    bus(1'b1, `PFLO_OFS_FLCTL, 16'h17FB); // active-low limit, source high is idle
    pins(2'b01);
    src_i[5] <= 1'b0;
    pins(2'b10);
    // independent mode: limit uses fault high bit, fault drives low only
    pwm_h_i <= 1'b1;
    pwm_l_i <= 1'b0;
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h0018);
    bus(1'b1, `PFLO_OFS_FLCTL, 16'h97FB);
    pins(2'b00);
    src_i[5] <= 1'b1;
    bus(1'b1, `PFLO_OFS_FLCTL, 16'h8039);
    src_i[7] <= 1'b1;
    pins(2'b11);
    src_i[7] <= 1'b0;
    // normal mode fault encodings and polarity, both fault states active
    pwm_h_i <= 1'b0;
    bus(1'b1, `PFLO_OFS_OUTCTL, 16'h0030);
    fault_case(2'b01, 1'b0, 2'b11, 2'b00);
    fault_case(2'b00, 1'b0, 2'b11, 2'b11);
    bus(1'b1, `PFLO_OFS_STATUS, 16'h0001); // clear the latched fault
    pins(2'b00);
    fault_case(2'b11, 1'b0, 2'b00, 2'b00);
    fault_case(2'b10, 1'b0, 2'b00, 2'b00);
    fault_case(2'b01, 1'b1, 2'b11, 2'b00);
    finish_test();
  end
  // ----------------------------------------
  // hang guard
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    finish_test();
  end
endmodule

// file: pflo_top.sv
// Purpose: override, fault, limit and trigger slice of one pwm channel
// Assumes: pwm_h_i/pwm_l_i come from duty and dead-time logic on clk_i
// Notes: wishbone classic slave, ack one cycle after request, 32-bit words
//
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "pflo_defines.svh"
module pflo_top
  import pflo_pkg::*;
#(
  parameter int NSRC = 32,
  parameter int CW = 13
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // time base
  input wire logic timebase_enable_i,
  input wire logic period_end_i,
  input wire logic [CW-1:0] count_i,
  // generated pwm and condition sources
  input wire logic pwm_h_i,
  input wire logic pwm_l_i,
  input wire logic [NSRC-1:0] src_i,
  // pins and trigger
  output logic high_output_o,
  output logic low_output_o,
  output logic adc_trig_o
);
  // refuse sizes the select decode and the 13-bit compare field cannot serve
  initial begin
    if (NSRC < 1 || NSRC > 32) $error("pflo_top: NSRC out of range");
    if (CW != 13) $error("pflo_top: compare field is 13 bits");
  end
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pflo_word_t outctl;   // output control
    pflo_word_t flctl;    // fault / limit control
    pflo_word_t trig;     // trigger compare value
    logic [1:0] ovr_en;   // applied override enables {h,l}
    logic [1:0] ovr_val;  // applied override values {h,l}
    logic flt_latch;      // latched fault condition
    logic flt_clr_req;    // software asked to clear the latch
    logic pin_h;          // registered pin levels
    logic pin_l;
    logic ack;
    logic err;
    logic [31:0] rdat;
  } pflo_state_s;
  pflo_state_s st_ff;
  pflo_state_s nxt_st;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // byte-lane merge used by every writable register
  function automatic pflo_word_t wmerge(input pflo_word_t old, input logic [31:0] d,
                                        input logic [3:0] sel);
    pflo_word_t r;
    r = old;
    if (sel[0]) r[7:0] = d[7:0];
    if (sel[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // ----------------------------------------
  // condition sources
  // ----------------------------------------
  logic lim_act;
  logic flt_raw;
  pflo_srcsel #(.NSRC(NSRC)) u_lim (
    .src_i(src_i),
    .sel_i(st_ff.flctl[`PFLO_FC_LIMIT_SOURCE_SELECT_HI:`PFLO_FC_LIMIT_SOURCE_SELECT_LO]),
    .act_low_i(st_ff.flctl[`PFLO_FC_LIMIT_POLARITY]),
    .active_o(lim_act)
  );
  pflo_srcsel #(.NSRC(NSRC)) u_flt (
    .src_i(src_i),
    .sel_i(st_ff.flctl[`PFLO_FC_FSRC_HI:`PFLO_FC_FSRC_LO]),
    .act_low_i(st_ff.flctl[`PFLO_FC_FPOL]),
    .active_o(flt_raw)
  );

  pflo_trig #(.CW(CW)) u_trig (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .enable_i(timebase_enable_i),
    .cmp_i(st_ff.trig[15:`PFLO_TRIG_LSB]),
    .count_i(count_i),
    .adc_trig_o(adc_trig_o)
  );

  // decoded configuration
  pflo_fmode_e fmode;
  logic indep;
  logic lim_on;
  logic flt_on;
  logic req;
  logic wr;
  assign fmode = pflo_fmode_e'(st_ff.flctl[`PFLO_FC_FMOD_HI:`PFLO_FC_FMOD_LO]);
  assign indep = st_ff.flctl[`PFLO_FC_IFLT];
  assign lim_on = st_ff.flctl[`PFLO_FC_CLEN] && lim_act;
  assign req = wb_cyc_i && wb_stb_i && !st_ff.ack && !st_ff.err;
  assign wr = req && wb_we_i;

  // fault condition seen by the override; reserved code acts as disabled
  always_comb begin
    unique case (fmode)
      PFLO_FM_LATCH: flt_on = flt_raw || st_ff.flt_latch;
      PFLO_FM_CYCLE: flt_on = flt_raw;
      PFLO_FM_RSVD: flt_on = 1'b0;
      PFLO_FM_OFF: flt_on = 1'b0;
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic act_h;
  logic act_l;
  logic sh;
  logic sl;
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.err = 1'b0;
    nxt_st.flt_clr_req = 1'b0;
    // bus: decode one aligned word per register
    if (req) begin
      nxt_st.rdat = 32'h0000_0000;
      unique case (wb_adr_i)
        `PFLO_OFS_OUTCTL: begin
          nxt_st.ack = 1'b1;
          nxt_st.rdat[15:0] = st_ff.outctl;
          if (wr) nxt_st.outctl = wmerge(st_ff.outctl, wb_dat_i, wb_sel_i);
        end
        `PFLO_OFS_TRIG: begin
          nxt_st.ack = 1'b1;
          nxt_st.rdat[15:0] = st_ff.trig & `PFLO_TRIG_MASK;
          if (wr) begin
            nxt_st.trig = wmerge(st_ff.trig, wb_dat_i, wb_sel_i) & `PFLO_TRIG_MASK;
          end
        end
        `PFLO_OFS_FLCTL: begin
          nxt_st.ack = 1'b1;
          nxt_st.rdat[15:0] = st_ff.flctl;
          if (wr) nxt_st.flctl = wmerge(st_ff.flctl, wb_dat_i, wb_sel_i);
        end
        `PFLO_OFS_STATUS: begin
          // status: bit0 latch, bit1 limit, bit2 fault; writing bit0 clears latch
          nxt_st.ack = 1'b1;
          nxt_st.rdat[2:0] = {flt_raw, lim_act, st_ff.flt_latch};
          if (wr && wb_sel_i[0] && wb_dat_i[0]) nxt_st.flt_clr_req = 1'b1;
        end
        default: begin
          nxt_st.err = 1'b1; // unmapped word
        end
      endcase
    end
    // latched fault: clear on a software request or on leaving latch mode; set wins
    if (flt_raw && fmode == PFLO_FM_LATCH) begin
      nxt_st.flt_latch = 1'b1;
    end else if (st_ff.flt_clr_req || (st_ff.flt_latch && fmode != PFLO_FM_LATCH)) begin
      nxt_st.flt_latch = 1'b0;
    end
    // override apply: sync waits for the boundary, else next edge
    if (!st_ff.outctl[`PFLO_OC_OVERRIDE_SYNC] || period_end_i) begin
      nxt_st.ovr_en = {st_ff.outctl[`PFLO_OC_OVRH], st_ff.outctl[`PFLO_OC_OVRL]};
      nxt_st.ovr_val = {st_ff.outctl[`PFLO_OC_OVDH], st_ff.outctl[`PFLO_OC_OVDL]};
    end
    // active levels, priority: fault, limit, override, generated
    sh = st_ff.outctl[`PFLO_OC_SWAP] ? pwm_l_i : pwm_h_i;
    sl = st_ff.outctl[`PFLO_OC_SWAP] ? pwm_h_i : pwm_l_i;
    act_h = st_ff.ovr_en[1] ? st_ff.ovr_val[1] : sh;
    act_l = st_ff.ovr_en[0] ? st_ff.ovr_val[0] : sl;
    if (!indep) begin
      if (lim_on) begin
        act_h = st_ff.outctl[`PFLO_OC_CDH];
        act_l = st_ff.outctl[`PFLO_OC_CDL];
      end
      if (flt_on) begin
        act_h = st_ff.outctl[`PFLO_OC_FDH];
        act_l = st_ff.outctl[`PFLO_OC_FDL];
      end
    end else begin
      // limit state bits are not consulted here at all
      if (lim_on) act_h = st_ff.outctl[`PFLO_OC_FDH];
      if (flt_on) act_l = st_ff.outctl[`PFLO_OC_FDL];
    end
    // polarity: active-low setting inverts the pin
    nxt_st.pin_h = act_h ^ st_ff.outctl[`PFLO_OC_HPOL];
    nxt_st.pin_l = act_l ^ st_ff.outctl[`PFLO_OC_LPOL];
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // software is trusted to leave control fields alone while enabled
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
      st_ff.outctl <= `PFLO_RST_OUTCTL;
      st_ff.flctl <= `PFLO_RST_FLCTL;
      st_ff.trig <= `PFLO_RST_TRIG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wb_ack_o = st_ff.ack;
  assign wb_err_o = st_ff.err;
  assign wb_dat_o = st_ff.rdat;
  assign high_output_o = st_ff.pin_h;
  assign low_output_o = st_ff.pin_l;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_limit_high_state: assert property (@(posedge clk_i) disable iff (rst_i)
    (!indep && lim_on && !flt_on) |=>
      high_output_o == ($past(st_ff.outctl[`PFLO_OC_CDH]) ^ $past(st_ff.outctl[`PFLO_OC_HPOL])))
    else $error("limit state not on high pin");
  chk_limit_low_state: assert property (@(posedge clk_i) disable iff (rst_i)
    (!indep && lim_on && !flt_on) |=>
      low_output_o == ($past(st_ff.outctl[`PFLO_OC_CDL]) ^ $past(st_ff.outctl[`PFLO_OC_LPOL])))
    else $error("limit state not on low pin");
  chk_indep_fault_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (indep && flt_on) |=>
      low_output_o == ($past(st_ff.outctl[`PFLO_OC_FDL]) ^ $past(st_ff.outctl[`PFLO_OC_LPOL])))
    else $error("independent fault not on low pin");
  chk_indep_ignore_cd: assert property (@(posedge clk_i) disable iff (rst_i)
    (indep && lim_on) |=>
      high_output_o == ($past(st_ff.outctl[`PFLO_OC_FDH]) ^ $past(st_ff.outctl[`PFLO_OC_HPOL])))
    else $error("limit state used in independent mode");
  chk_swap_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.outctl[`PFLO_OC_SWAP] && !lim_on && !flt_on && !st_ff.ovr_en[1]) |=>
      high_output_o == ($past(pwm_l_i) ^ $past(st_ff.outctl[`PFLO_OC_HPOL])))
    else $error("swap routing wrong");
  chk_sync_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.outctl[`PFLO_OC_OVERRIDE_SYNC] && !period_end_i) |=> $stable(st_ff.ovr_en))
    else $error("override applied off boundary");
  chk_async_apply: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_ff.outctl[`PFLO_OC_OVERRIDE_SYNC] |=>
      st_ff.ovr_en == $past({st_ff.outctl[`PFLO_OC_OVRH], st_ff.outctl[`PFLO_OC_OVRL]}))
    else $error("override not applied next edge");
  chk_trig_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && $past(wb_adr_i) == `PFLO_OFS_TRIG) |-> wb_dat_o[2:0] == 3'h0)
    else $error("trigger low bits nonzero");
  chk_fault_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (fmode == PFLO_FM_OFF) |-> !flt_on)
    else $error("disabled fault still active");
  chk_limit_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_ff.flctl[`PFLO_FC_CLEN] |-> !lim_on)
    else $error("limit acts while disabled");
  chk_bus_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // ----------------------------------------
  // checks on fault forcing
  // ----------------------------------------
  // fault outranks limit, so the normal mode checks only need the fault on
  // the set-wins check guards a clear landing while the fault is still present
  chk_fault_normal_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (!indep && flt_on) |=>
      high_output_o == ($past(st_ff.outctl[`PFLO_OC_FDH]) ^ $past(st_ff.outctl[`PFLO_OC_HPOL])))
    else $error("fault state not on high pin");
  chk_fault_normal_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (!indep && flt_on) |=>
      low_output_o == ($past(st_ff.outctl[`PFLO_OC_FDL]) ^ $past(st_ff.outctl[`PFLO_OC_LPOL])))
    else $error("fault state not on low pin");
  chk_latch_set_wins: assert property (@(posedge clk_i) disable iff (rst_i)
    (fmode == PFLO_FM_LATCH && flt_raw) |=> st_ff.flt_latch)
    else $error("latched fault not set");
  chk_latch_sw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.flt_clr_req && !flt_raw) |=> !st_ff.flt_latch)
    else $error("latched fault not cleared");
  // cycle mode has no memory, so the force drops with the source
  chk_cycle_follows_src: assert property (@(posedge clk_i) disable iff (rst_i)
    (fmode == PFLO_FM_CYCLE) |-> (flt_on == flt_raw))
    else $error("cycle fault does not follow source");
  // the reserved code is served as disabled rather than left undefined
  chk_rsvd_mode_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    (fmode == PFLO_FM_RSVD) |-> !flt_on)
    else $error("reserved fault mode active");

  // ----------------------------------------
  // checks on routing and overrides
  // ----------------------------------------
  // each route check excludes every forcing source that outranks it
  // a broken swap mux shows on the low pin even when the high pin looks right
  chk_plain_high_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_ff.outctl[`PFLO_OC_SWAP] && !lim_on && !flt_on && !st_ff.ovr_en[1]) |=>
      high_output_o == ($past(pwm_h_i) ^ $past(st_ff.outctl[`PFLO_OC_HPOL])))
    else $error("plain routing wrong");
  chk_swap_low_route: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.outctl[`PFLO_OC_SWAP] && !lim_on && !flt_on && !st_ff.ovr_en[0]) |=>
      low_output_o == ($past(pwm_h_i) ^ $past(st_ff.outctl[`PFLO_OC_LPOL])))
    else $error("swap routing wrong on low pin");
  chk_override_high_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.ovr_en[1] && !lim_on && !flt_on) |=>
      high_output_o == ($past(st_ff.ovr_val[1]) ^ $past(st_ff.outctl[`PFLO_OC_HPOL])))
    else $error("override level wrong on high pin");
  chk_ovr_value_apply: assert property (@(posedge clk_i) disable iff (rst_i)
    !st_ff.outctl[`PFLO_OC_OVERRIDE_SYNC] |=>
      st_ff.ovr_val == $past({st_ff.outctl[`PFLO_OC_OVDH], st_ff.outctl[`PFLO_OC_OVDL]}))
    else $error("override value not applied next edge");
  chk_sync_value_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.outctl[`PFLO_OC_OVERRIDE_SYNC] && !period_end_i) |=> $stable(st_ff.ovr_val))
    else $error("override value applied off boundary");
  // at the boundary the applied enables take the written override enable bits
  chk_sync_boundary_apply: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_ff.outctl[`PFLO_OC_OVERRIDE_SYNC] && period_end_i) |=>
      st_ff.ovr_en == $past({st_ff.outctl[`PFLO_OC_OVRH], st_ff.outctl[`PFLO_OC_OVRL]}))
    else $error("override not applied at boundary");

  // ----------------------------------------
  // checks on the register bus
  // ----------------------------------------
  // only word-aligned offsets exist; a misaligned byte address is refused
  // ack and err never pulse together, or a master could take bad data
  chk_bus_ack_mapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_adr_i[1:0] == 2'h0) |=> (wb_ack_o && !wb_err_o))
    else $error("mapped access not acknowledged");
  chk_bus_err_unmapped: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && wb_adr_i[1:0] != 2'h0) |=> (wb_err_o && !wb_ack_o))
    else $error("unmapped access not refused");
  chk_trig_low_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    st_ff.trig[2:0] == 3'h0)
    else $error("trigger low bits stored");
  cover property (@(posedge clk_i) disable iff (rst_i) lim_on && !indep);
  cover property (@(posedge clk_i) disable iff (rst_i) flt_on && indep);
  cover property (@(posedge clk_i) disable iff (rst_i) st_ff.flt_latch && st_ff.flt_clr_req);
  cover property (@(posedge clk_i) disable iff (rst_i)
    st_ff.outctl[`PFLO_OC_OVERRIDE_SYNC] && period_end_i);
endmodule

// file: pflo_trig.sv
// Purpose: primary trigger compare against the local time base counter
// Assumes: counter is the 13-bit period counter of the local time base
// Notes: one pulse per match entry, so a stalled counter fires once
`timescale 1ns/1ps
`include "pflo_defines.svh"
module pflo_trig
  import pflo_pkg::*;
#(
  parameter int CW = 13
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic [CW-1:0] cmp_i,
  input wire logic [CW-1:0] count_i,
  output logic adc_trig_o
);
  initial begin
    if (CW != 13) $error("pflo_trig: compare field is 13 bits");
  end
  typedef struct packed {
    logic match;
    logic pulse;
  } pflo_trst_s;
  pflo_trst_s st_ff;
  pflo_trst_s nxt_st;
  // ----------------------------------------
  // compare and edge
  // ----------------------------------------
  always_comb begin
    nxt_st.match = enable_i && (count_i == cmp_i);
    nxt_st.pulse = nxt_st.match && !st_ff.match;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign adc_trig_o = st_ff.pulse;
  chk_trig_on_match: assert property (@(posedge clk_i) disable iff (rst_i)
    (enable_i && count_i == cmp_i && !st_ff.match) |=> adc_trig_o)
    else $error("trigger missed on compare match");
  cover property (@(posedge clk_i) disable iff (rst_i) adc_trig_o);
endmodule
